// ==== rie_countdown.sv ====
`timescale 1ns/100ps
`default_nettype none

module rie_countdown (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic minute_tick,
  input wire logic load,
  input wire logic [rie_pkg::CD_W-1:0] load_value,
  // State
  output logic [rie_pkg::CD_W-1:0] value,
  output logic timeout
);

  rie_pkg::rie_cd_state_t st;
  rie_pkg::rie_cd_state_t next_st;

  // A load in the same cycle as a minute tick wins and loses that tick
  always_comb begin
    next_st = st;
    next_st.timeout = 1'b0;
    if (load) begin
      next_st.value = load_value;
    end else if (minute_tick) begin
      if (st.value == rie_pkg::CD_EXPIRED) begin
        next_st.timeout = 1'b1;
      end else begin
        next_st.value = st.value - rie_pkg::CD_STEP;
        next_st.timeout = (st.value == rie_pkg::CD_ZERO);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= rie_pkg::CD_STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign value = st.value;
  assign timeout = st.timeout;

  property p_cd_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      st.value == rie_pkg::CD_EXPIRED && !load
      |=> st.value == rie_pkg::CD_EXPIRED;
  endproperty
  a_cd_hold: assert property (p_cd_hold)
    else $error("expired countdown moved without a load");

  property p_cd_dec;
    @(posedge clk_sys) disable iff (!rst_n)
      minute_tick && !load && st.value != rie_pkg::CD_EXPIRED
      |=> st.value == $past(st.value) - rie_pkg::CD_STEP;
  endproperty
  a_cd_dec: assert property (p_cd_dec)
    else $error("minute tick did not decrement countdown");

  property p_cd_stable;
    @(posedge clk_sys) disable iff (!rst_n)
      !minute_tick && !load |=> $stable(st.value);
  endproperty
  a_cd_stable: assert property (p_cd_stable)
    else $error("countdown changed with no tick or load");

endmodule

`default_nettype wire

// ==== rie_pkg.sv ====
package rie_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_ENABLE = 32'h0020_4018;
  localparam logic [31:0] ADDR_COUNTDOWN = 32'h0020_401c;
  localparam logic [31:0] ADDR_FLAGS = 32'h0020_4020;

  // Event bit positions, shared by enable and flag registers
  localparam int BIT_TICK1 = 9;
  localparam int BIT_TICK0 = 8;
  localparam int BIT_HALF = 7;
  localparam int BIT_RSVD = 6;
  localparam int BIT_HOUR = 5;
  localparam int BIT_SECOND = 4;
  localparam int BIT_DAY = 3;
  localparam int BIT_ALARM = 2;
  localparam int BIT_MINUTE = 1;
  localparam int BIT_TIMEOUT = 0;

  localparam int EVT_W = 10;
  localparam int CD_W = 6;
  localparam int HALF_DIV_W = 24;

  localparam logic [EVT_W-1:0] ENABLE_WMASK = 10'h3bf;
  localparam logic [EVT_W-1:0] ENABLE_RESET = 10'h000;
  localparam logic [EVT_W-1:0] FLAGS_RESET = 10'h000;

  // All ones in the countdown field is the expired value, -1
  localparam logic [CD_W-1:0] CD_EXPIRED = 6'h3f;
  localparam logic [CD_W-1:0] CD_RESET = 6'h3f;
  localparam logic [CD_W-1:0] CD_ZERO = 6'h00;
  localparam logic [CD_W-1:0] CD_STEP = 6'h01;

  // Half-second divider from the system clock
  localparam int CLK_HZ = 20_000_000;
  localparam int HALF_SEC_MS = 500;
  localparam int HALF_SEC_CYCLES = CLK_HZ / 1000 * HALF_SEC_MS;

  typedef struct packed {
    logic [CD_W-1:0] value;
    logic timeout;
  } rie_cd_state_t;

  typedef struct packed {
    logic [EVT_W-1:0] enable;
    logic [EVT_W-1:0] flags;
    logic [HALF_DIV_W-1:0] half_div;
    logic [31:0] rd_data;
    logic irq;
  } rie_top_state_t;

  localparam rie_cd_state_t CD_STATE_RESET = '{
    value: CD_RESET,
    timeout: 1'b0
  };

  localparam rie_top_state_t TOP_STATE_RESET = '{
    enable: ENABLE_RESET,
    flags: FLAGS_RESET,
    half_div: 24'h000000,
    rd_data: 32'h0000_0000,
    irq: 1'b0
  };

endpackage

// ==== rie_top.sv ====
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`default_nettype none

module rie_top #(
  parameter int HALF_SEC_CYCLES = rie_pkg::HALF_SEC_CYCLES
) (
  // System
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rd_data,
  // Time-of-day events, one-cycle pulses
  input wire logic sampling_tick_1,
  input wire logic sampling_tick_0,
  input wire logic hour_tick,
  input wire logic second_tick,
  input wire logic day_rollover,
  input wire logic alarm_match,
  input wire logic minute_tick,
  // Interrupt
  output logic irq
);

  localparam logic [rie_pkg::HALF_DIV_W-1:0] HALF_LAST =
    rie_pkg::HALF_DIV_W'(HALF_SEC_CYCLES - 1);

  logic rst_meta_n;
  logic rst_n;
  rie_pkg::rie_top_state_t st;
  rie_pkg::rie_top_state_t next_st;
  logic [rie_pkg::EVT_W-1:0] events;
  logic [rie_pkg::EVT_W-1:0] set_mask;
  logic half_tick;
  logic cd_load;
  logic [rie_pkg::CD_W-1:0] cd_value;
  logic cd_timeout;
  logic wr_enable;
  logic wr_flags;

  function automatic logic hit(
    input logic [31:0] addr,
    input logic [31:0] offset
  );
    hit = (addr == offset);
  endfunction

  // Release of reset is synchronised; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  assign wr_enable = reg_wr && hit(reg_addr, rie_pkg::ADDR_ENABLE);
  assign wr_flags = reg_wr && hit(reg_addr, rie_pkg::ADDR_FLAGS);
  assign cd_load = reg_wr && hit(reg_addr, rie_pkg::ADDR_COUNTDOWN);

  rie_countdown u_countdown (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .minute_tick(minute_tick),
    .load(cd_load),
    .load_value(reg_wr_data[rie_pkg::CD_W-1:0]),
    .value(cd_value),
    .timeout(cd_timeout)
  );

  // Divider stops and clears while disabled, so the first event after
  // enabling comes a full half second later
  assign half_tick = st.enable[rie_pkg::BIT_HALF] &&
    (st.half_div == HALF_LAST);

  always_comb begin
    events = '0;
    events[rie_pkg::BIT_TICK1] = sampling_tick_1;
    events[rie_pkg::BIT_TICK0] = sampling_tick_0;
    events[rie_pkg::BIT_HALF] = half_tick;
    events[rie_pkg::BIT_HOUR] = hour_tick;
    events[rie_pkg::BIT_SECOND] = second_tick;
    events[rie_pkg::BIT_DAY] = day_rollover;
    events[rie_pkg::BIT_ALARM] = alarm_match;
    events[rie_pkg::BIT_MINUTE] = minute_tick;
    events[rie_pkg::BIT_TIMEOUT] = cd_timeout;
  end

  // Disabled events are dropped here and never reach a flag
  assign set_mask = events & st.enable;

  always_comb begin
    next_st = st;
    if (!st.enable[rie_pkg::BIT_HALF] || half_tick) begin
      next_st.half_div = '0;
    end else begin
      next_st.half_div = st.half_div + 24'h000001;
    end
    if (wr_enable) begin
      next_st.enable = reg_wr_data[rie_pkg::EVT_W-1:0] &
        rie_pkg::ENABLE_WMASK;
    end
    if (wr_flags) begin
      next_st.flags = st.flags & ~reg_wr_data[rie_pkg::EVT_W-1:0];
    end
    // Set after clear, so an event in the clearing cycle survives
    next_st.flags = next_st.flags | set_mask;
    next_st.rd_data = '0;
    if (reg_rd) begin
      if (hit(reg_addr, rie_pkg::ADDR_ENABLE)) begin
        next_st.rd_data[rie_pkg::EVT_W-1:0] = st.enable;
      end else if (hit(reg_addr, rie_pkg::ADDR_COUNTDOWN)) begin
        next_st.rd_data[rie_pkg::CD_W-1:0] = cd_value;
      end else if (hit(reg_addr, rie_pkg::ADDR_FLAGS)) begin
        next_st.rd_data[rie_pkg::EVT_W-1:0] = st.flags;
      end else begin
        next_st.rd_data = '0;
      end
    end
    next_st.irq = |(next_st.flags & next_st.enable);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= rie_pkg::TOP_STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rd_data = st.rd_data;
  assign irq = st.irq;

  property p_tick1_set;
    @(posedge clk_sys) disable iff (!rst_n)
      sampling_tick_1 && st.enable[rie_pkg::BIT_TICK1]
      |=> st.flags[rie_pkg::BIT_TICK1];
  endproperty
  a_tick1_set: assert property (p_tick1_set)
    else $error("enabled sampling tick 1 did not set its flag");

  property p_tick0_set;
    @(posedge clk_sys) disable iff (!rst_n)
      sampling_tick_0 && st.enable[rie_pkg::BIT_TICK0]
      |=> st.flags[rie_pkg::BIT_TICK0];
  endproperty
  a_tick0_set: assert property (p_tick0_set)
    else $error("enabled sampling tick 0 did not set its flag");

  property p_tick1_block;
    @(posedge clk_sys) disable iff (!rst_n)
      !st.enable[rie_pkg::BIT_TICK1] && !st.flags[rie_pkg::BIT_TICK1]
      |=> !st.flags[rie_pkg::BIT_TICK1];
  endproperty
  a_tick1_block: assert property (p_tick1_block)
    else $error("disabled sampling tick 1 set its flag");

  property p_tick0_block;
    @(posedge clk_sys) disable iff (!rst_n)
      !st.enable[rie_pkg::BIT_TICK0] && !st.flags[rie_pkg::BIT_TICK0]
      |=> !st.flags[rie_pkg::BIT_TICK0];
  endproperty
  a_tick0_block: assert property (p_tick0_block)
    else $error("disabled sampling tick 0 set its flag");

  property p_half_on;
    @(posedge clk_sys) disable iff (!rst_n)
      st.enable[rie_pkg::BIT_HALF] && st.half_div == HALF_LAST
      |=> st.flags[rie_pkg::BIT_HALF] && st.half_div == '0;
  endproperty
  a_half_on: assert property (p_half_on)
    else $error("half-second event missing at divider end");

  property p_half_off;
    @(posedge clk_sys) disable iff (!rst_n)
      !st.enable[rie_pkg::BIT_HALF] && !st.flags[rie_pkg::BIT_HALF]
      |=> !st.flags[rie_pkg::BIT_HALF] && st.half_div == '0;
  endproperty
  a_half_off: assert property (p_half_off)
    else $error("half-second event while generation is off");

  property p_rsvd_bit;
    @(posedge clk_sys) disable iff (!rst_n)
      reg_rd |=> !reg_rd_data[rie_pkg::BIT_RSVD] &&
      !st.enable[rie_pkg::BIT_RSVD] && !st.flags[rie_pkg::BIT_RSVD];
  endproperty
  a_rsvd_bit: assert property (p_rsvd_bit)
    else $error("reserved enable bit 6 is not zero");

  property p_hour_set;
    @(posedge clk_sys) disable iff (!rst_n)
      hour_tick && st.enable[rie_pkg::BIT_HOUR]
      |=> st.flags[rie_pkg::BIT_HOUR];
  endproperty
  a_hour_set: assert property (p_hour_set)
    else $error("enabled hour event did not set its flag");

  property p_hour_block;
    @(posedge clk_sys) disable iff (!rst_n)
      !st.enable[rie_pkg::BIT_HOUR] && !st.flags[rie_pkg::BIT_HOUR]
      |=> !st.flags[rie_pkg::BIT_HOUR];
  endproperty
  a_hour_block: assert property (p_hour_block)
    else $error("disabled hour event set its flag");

  property p_second_set;
    @(posedge clk_sys) disable iff (!rst_n)
      second_tick && st.enable[rie_pkg::BIT_SECOND]
      |=> st.flags[rie_pkg::BIT_SECOND];
  endproperty
  a_second_set: assert property (p_second_set)
    else $error("enabled seconds event did not set its flag");

  property p_second_block;
    @(posedge clk_sys) disable iff (!rst_n)
      !st.enable[rie_pkg::BIT_SECOND] && !st.flags[rie_pkg::BIT_SECOND]
      |=> !st.flags[rie_pkg::BIT_SECOND];
  endproperty
  a_second_block: assert property (p_second_block)
    else $error("disabled seconds event set its flag");

  property p_day_set;
    @(posedge clk_sys) disable iff (!rst_n)
      day_rollover && st.enable[rie_pkg::BIT_DAY]
      |=> st.flags[rie_pkg::BIT_DAY];
  endproperty
  a_day_set: assert property (p_day_set)
    else $error("enabled midnight event did not set its flag");

  property p_day_block;
    @(posedge clk_sys) disable iff (!rst_n)
      !st.enable[rie_pkg::BIT_DAY] && !st.flags[rie_pkg::BIT_DAY]
      |=> !st.flags[rie_pkg::BIT_DAY];
  endproperty
  a_day_block: assert property (p_day_block)
    else $error("disabled midnight event set its flag");

  property p_alarm_gate;
    @(posedge clk_sys) disable iff (!rst_n)
      !st.flags[rie_pkg::BIT_ALARM]
      |=> st.flags[rie_pkg::BIT_ALARM] ==
      $past(alarm_match && st.enable[rie_pkg::BIT_ALARM]);
  endproperty
  a_alarm_gate: assert property (p_alarm_gate)
    else $error("alarm flag does not follow gated alarm match");

  property p_minute_set;
    @(posedge clk_sys) disable iff (!rst_n)
      minute_tick && st.enable[rie_pkg::BIT_MINUTE]
      |=> st.flags[rie_pkg::BIT_MINUTE];
  endproperty
  a_minute_set: assert property (p_minute_set)
    else $error("enabled minute event did not set its flag");

  property p_minute_block;
    @(posedge clk_sys) disable iff (!rst_n)
      !st.enable[rie_pkg::BIT_MINUTE] && !st.flags[rie_pkg::BIT_MINUTE]
      |=> !st.flags[rie_pkg::BIT_MINUTE];
  endproperty
  a_minute_block: assert property (p_minute_block)
    else $error("disabled minute event set its flag");

  property p_expired_post;
    @(posedge clk_sys) disable iff (!rst_n)
      minute_tick && !cd_load && cd_value == rie_pkg::CD_EXPIRED &&
      st.enable[rie_pkg::BIT_TIMEOUT] && !wr_enable
      |=> ##1 st.flags[rie_pkg::BIT_TIMEOUT];
  endproperty
  a_expired_post: assert property (p_expired_post)
    else $error("timeout not posted on minute tick at minus one");

  property p_zero_expire;
    @(posedge clk_sys) disable iff (!rst_n)
      minute_tick && !cd_load && cd_value == rie_pkg::CD_ZERO
      |=> cd_value == rie_pkg::CD_EXPIRED && cd_timeout;
  endproperty
  a_zero_expire: assert property (p_zero_expire)
    else $error("countdown did not expire to minus one");

  property p_cd_read;
    @(posedge clk_sys) disable iff (!rst_n)
      reg_rd && hit(reg_addr, rie_pkg::ADDR_COUNTDOWN)
      |=> reg_rd_data == {26'h0000000, $past(cd_value)};
  endproperty
  a_cd_read: assert property (p_cd_read)
    else $error("countdown read has nonzero upper bits");

  property p_set_wins;
    @(posedge clk_sys) disable iff (!rst_n)
      wr_flags && second_tick && st.enable[rie_pkg::BIT_SECOND]
      |=> st.flags[rie_pkg::BIT_SECOND];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost against a flag clear");

  property p_flag_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      wr_flags && reg_wr_data[rie_pkg::BIT_HOUR] &&
      !(hour_tick && st.enable[rie_pkg::BIT_HOUR])
      |=> !st.flags[rie_pkg::BIT_HOUR];
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("writing one did not clear the hour flag");

  property p_timeout_flag;
    @(posedge clk_sys) disable iff (!rst_n)
      cd_timeout && st.enable[rie_pkg::BIT_TIMEOUT]
      |=> st.flags[rie_pkg::BIT_TIMEOUT];
  endproperty
  a_timeout_flag: assert property (p_timeout_flag)
    else $error("countdown timeout did not set its flag");

  property p_irq_level;
    @(posedge clk_sys) disable iff (!rst_n)
      irq == (|(st.flags & st.enable));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt does not match enabled flags");

  property p_rd_once;
    @(posedge clk_sys) disable iff (!rst_n)
      !reg_rd |=> reg_rd_data == 32'h0000_0000;
  endproperty
  a_rd_once: assert property (p_rd_once)
    else $error("read data stands outside the answer cycle");

endmodule

`default_nettype wire

// ==== test_rie_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module test_rie_top;
  localparam int HALF = 16;
  localparam logic [31:0] ADDR_NONE = 32'h0020_4024;

  logic clk_sys;
  logic reset_n;
  logic [31:0] reg_addr;
  logic [31:0] reg_wr_data;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rd_data;
  logic irq;
  logic [9:0] ev;
  int miscompares;
  int num_checks;
  int cycles;
  int bits [7] = '{9, 8, 5, 4, 3, 2, 1};

  // Short half-second divider keeps the run brief
  rie_top #(
    .HALF_SEC_CYCLES(HALF)
  ) rie_top_i (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rd_data(reg_rd_data),
    .sampling_tick_1(ev[9]),
    .sampling_tick_0(ev[8]),
    .hour_tick(ev[5]),
    .second_tick(ev[4]),
    .day_rollover(ev[3]),
    .alarm_match(ev[2]),
    .minute_tick(ev[1]),
    .irq(irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rd_data, exp);
  endtask

  task automatic pulse(input int b);
    @(posedge clk_sys);
    ev[b] <= 1'b1;
    @(posedge clk_sys);
    ev[b] <= 1'b0;
  endtask

  // Two edges cover the registered irq and the timeout pipeline
  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    reset_n = 1'b0;
    reg_addr = 32'h0;
    reg_wr_data = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ev = 10'h000;
    miscompares = 0;
    num_checks = 0;
    cycles = 0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(rie_pkg::ADDR_ENABLE, 32'h0);
    rd(rie_pkg::ADDR_COUNTDOWN, 32'h3f);
    rd(rie_pkg::ADDR_FLAGS, 32'h0);
    irq_chk(1'b0);
    wr(rie_pkg::ADDR_ENABLE, 32'hffff_ffff);
    rd(rie_pkg::ADDR_ENABLE, {22'h0, rie_pkg::ENABLE_WMASK});
    wr(rie_pkg::ADDR_ENABLE, 32'h0);
    wr(rie_pkg::ADDR_COUNTDOWN, 32'hffff_ffd5);
    rd(rie_pkg::ADDR_COUNTDOWN, 32'h15);
    wr(rie_pkg::ADDR_COUNTDOWN, 32'h3e);
    rd(rie_pkg::ADDR_COUNTDOWN, 32'h3e);
    wr(ADDR_NONE, 32'hffff_ffff);
    rd(ADDR_NONE, 32'h0);
    rd(rie_pkg::ADDR_ENABLE, 32'h0);
    // Each of the seven input events: ignored while disabled, flagged while enabled
    foreach (bits[i]) begin
      wr(rie_pkg::ADDR_ENABLE, 32'h0);
      pulse(bits[i]);
      rd(rie_pkg::ADDR_FLAGS, 32'h0);
      wr(rie_pkg::ADDR_ENABLE, 32'h1 << bits[i]);
      pulse(bits[i]);
      rd(rie_pkg::ADDR_FLAGS, 32'h1 << bits[i]);
      irq_chk(1'b1);
      wr(rie_pkg::ADDR_FLAGS, 32'h1 << bits[i]);
      rd(rie_pkg::ADDR_FLAGS, 32'h0);
      irq_chk(1'b0);
    end
    // Masking a set flag drops irq but keeps the flag
    wr(rie_pkg::ADDR_ENABLE, 32'h20);
    pulse(5);
    wr(rie_pkg::ADDR_ENABLE, 32'h0);
    irq_chk(1'b0);
    rd(rie_pkg::ADDR_FLAGS, 32'h20);
    wr(rie_pkg::ADDR_ENABLE, 32'h20);
    irq_chk(1'b1);
    wr(rie_pkg::ADDR_FLAGS, 32'h3ff);
    // Clear and event in the same cycle: the event wins
    wr(rie_pkg::ADDR_ENABLE, 32'h10);
    @(posedge clk_sys);
    ev[4] <= 1'b1;
    reg_wr <= 1'b1;
    reg_addr <= rie_pkg::ADDR_FLAGS;
    reg_wr_data <= 32'h10;
    @(posedge clk_sys);
    ev[4] <= 1'b0;
    reg_wr <= 1'b0;
    rd(rie_pkg::ADDR_FLAGS, 32'h10);
    wr(rie_pkg::ADDR_FLAGS, 32'h3ff);
    // Half-second generator
    wr(rie_pkg::ADDR_ENABLE, 32'h80);
    repeat (HALF + 4) @(posedge clk_sys);
    rd(rie_pkg::ADDR_FLAGS, 32'h80);
    irq_chk(1'b1);
    wr(rie_pkg::ADDR_ENABLE, 32'h0);
    wr(rie_pkg::ADDR_FLAGS, 32'h3ff);
    repeat (3 * HALF) @(posedge clk_sys);
    rd(rie_pkg::ADDR_FLAGS, 32'h0);
    // Countdown started just after a minute tick, run to expiry
    wr(rie_pkg::ADDR_ENABLE, 32'h1);
    pulse(1);
    wr(rie_pkg::ADDR_COUNTDOWN, 32'h2);
    pulse(1);
    rd(rie_pkg::ADDR_COUNTDOWN, 32'h1);
    pulse(1);
    rd(rie_pkg::ADDR_COUNTDOWN, 32'h0);
    rd(rie_pkg::ADDR_FLAGS, 32'h0);
    pulse(1);
    irq_chk(1'b1);
    rd(rie_pkg::ADDR_COUNTDOWN, 32'h3f);
    rd(rie_pkg::ADDR_FLAGS, 32'h1);
    wr(rie_pkg::ADDR_FLAGS, 32'h1);
    pulse(1);
    rd(rie_pkg::ADDR_COUNTDOWN, 32'h3f);
    // Enabling while expired posts at the next minute tick
    wr(rie_pkg::ADDR_ENABLE, 32'h0);
    wr(rie_pkg::ADDR_FLAGS, 32'h1);
    pulse(1);
    irq_chk(1'b0);
    rd(rie_pkg::ADDR_FLAGS, 32'h0);
    wr(rie_pkg::ADDR_ENABLE, 32'h1);
    pulse(1);
    irq_chk(1'b1);
    rd(rie_pkg::ADDR_FLAGS, 32'h1);
    wr(rie_pkg::ADDR_COUNTDOWN, 32'h3);
    rd(rie_pkg::ADDR_COUNTDOWN, 32'h3);
    // Reset in mid-run returns every register to its reset value
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    irq_chk(1'b0);
    rd(rie_pkg::ADDR_COUNTDOWN, 32'h3f);
    rd(rie_pkg::ADDR_FLAGS, 32'h0);
    rd(rie_pkg::ADDR_ENABLE, 32'h0);
    close_out();
  end
endmodule

`default_nettype wire
